// *** pkg/eag_pkg.sv ***
// Package of modes, widths and carrier structs for the effective address generator.
package eag_pkg;

   localparam int unsigned ADDR_W      = 16;
   localparam int unsigned BYTE_W      = 8;
   localparam int unsigned BUS_W_FULL  = 16;
   localparam int unsigned BUS_W_8K    = 13;
   localparam int unsigned BUS_W_4K    = 12;
   localparam logic [7:0]  ZERO_PAGE   = 8'h00;
   localparam logic [15:0] ADDR_RESET  = 16'h0000;
   localparam logic [15:0] ADDR_ONE    = 16'h0001;
   localparam int unsigned MEM_DEPTH   = 4;

   // Addressing modes requested by the instruction decoder.
   typedef enum logic [3:0] {
      MODE_IMPLIED    = 4'h0,
      MODE_ABSOLUTE   = 4'h1,
      MODE_ZERO_PAGE  = 4'h2,
      MODE_ZP_INDEXED = 4'h3,
      MODE_ABS_INDEXED= 4'h4,
      MODE_RELATIVE   = 4'h5,
      MODE_IDX_IND    = 4'h6,
      MODE_IND_IDX    = 4'h7,
      MODE_ABS_IND    = 4'h8
   } mode_e;

   // Sequencer states; Gray coded along the pointer path.
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_PTR_LO = 3'b001,
      ST_PTR_HI = 3'b011,
      ST_DONE   = 3'b010
   } state_e;

   // One address request from the decoder.
   typedef struct packed {
      mode_e       mode;
      logic        use_second;   // Selects the second index register.
      logic [7:0]  byte2;
      logic [7:0]  byte3;
      logic [15:0] next_pc;      // Address of the following instruction.
   } request_s;

   // Pointer read towards the memory system.
   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
   } mem_req_s;

   // Result handed back to the core.
   typedef struct packed {
      logic        valid;
      logic        load_pc;      // Result goes into the program counter.
      logic [15:0] addr;
   } result_s;

endpackage : eag_pkg

// *** design/byte_store.sv ***
// Small register memory holding the pointer low byte read back from memory.
`timescale 1ns/1ns
module byte_store
   import eag_pkg::*;
#(
   parameter int unsigned DEPTH = MEM_DEPTH
) (
   // Clock, reset and enable
   input  wire logic                     clock,
   input  wire logic                     rst,
   input  wire logic                     enable,
   // Write port
   input  wire logic                     write_en,
   input  wire logic [$clog2(DEPTH)-1:0] write_index,
   input  wire logic [BYTE_W-1:0]        write_data,
   // Read port
   input  wire logic [$clog2(DEPTH)-1:0] read_index,
   output logic      [BYTE_W-1:0]        read_data
);

   if (DEPTH < 2) begin : g_depth_check
      $error("byte_store needs at least two entries.");
   end

   logic [BYTE_W-1:0] cells [DEPTH];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) cells[i] <= '0;
      end else if (enable && write_en) begin
         cells[write_index] <= write_data;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         read_data <= '0;
      end else if (enable) begin
         read_data <= cells[read_index];
      end
   end

endmodule : byte_store

// *** design/effective_address_generator.sv ***
// Effective address generation datapath for the eight-bit processor core.
`timescale 1ns/1ns
// Operation
// RULE1: Absolute: low byte from byte two, high byte from byte three.
// RULE2: Zero page: byte two is the low byte, high byte forced zero.
// RULE3: Indexed zero page: byte two plus index, carry dropped, page zero.
// RULE4: Indexed absolute: selected index added to sixteen-bit base from bytes two, three.
// RULE5: Implied: no address bytes used; operand location comes from the opcode.
// RULE6: Branch: byte two is signed offset from next instruction address.
// RULE7: Indexed indirect: byte two plus first index, carry dropped, pointer read.
// RULE8: Indexed indirect: both pointer byte reads stay within page zero.
// RULE9: Indirect indexed: pointer low plus second index, carry into high byte.
// RULE10: Absolute indirect: pointer from bytes two, three; result loads program counter.
// RULE11: Variant driving only thirteen lowest address lines, 8K space.
// RULE12: Variant driving only twelve lowest address lines, 4K space.
module effective_address_generator
   import eag_pkg::*;
#(
   parameter int unsigned BUS_WIDTH = BUS_W_FULL
) (
   // Clock, reset and enable
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic                 clock_enable,
   // Index registers
   input  wire logic [BYTE_W-1:0]    index_first,
   input  wire logic [BYTE_W-1:0]    index_second,
   // Request from the decoder
   input  wire logic                 request_valid,
   input  wire request_s             request,
   output logic                      request_ready,
   // Pointer reads towards memory
   output mem_req_s                  mem_req,
   input  wire logic                 mem_data_valid,
   input  wire logic [BYTE_W-1:0]    mem_data,
   // Result
   output result_s                   result,
   output logic [BUS_WIDTH-1:0]      external_address_lines
);

   if (BUS_WIDTH != BUS_W_FULL && BUS_WIDTH != BUS_W_8K && BUS_WIDTH != BUS_W_4K) begin : g_width_check
      $error("BUS_WIDTH must be 16, 13 or 12.");
   end

   // ----------------------------------------------------------------
   // Request capture
   // ----------------------------------------------------------------
   state_e      state;
   request_s    held;
   logic [15:0] ptr;
   logic [7:0]  low_byte;
   logic [7:0]  y_snap;
   logic        took;

   assign took = request_valid && request_ready;

   function automatic logic [7:0] zp_add(input logic [7:0] a, input logic [7:0] b);
      zp_add = a + b;
   endfunction : zp_add

   // Combinational result for modes that need no memory read.
   logic [15:0] direct_addr;
   logic        direct_pc;
   logic [7:0]  sel_index;

   always_comb begin
      sel_index   = request.use_second ? index_second : index_first;
      direct_addr = ADDR_RESET;
      direct_pc   = 1'b0;
      case (request.mode)
         MODE_ABSOLUTE:    direct_addr = {request.byte3, request.byte2}; // RULE1
         MODE_ZERO_PAGE:   direct_addr = {ZERO_PAGE, request.byte2}; // RULE2
         MODE_ZP_INDEXED:  direct_addr = {ZERO_PAGE, zp_add(request.byte2, sel_index)}; // RULE3
         MODE_ABS_INDEXED: direct_addr = {request.byte3, request.byte2} + {8'h00, sel_index}; // RULE4
         MODE_RELATIVE: begin
            direct_addr = request.next_pc + {{8{request.byte2[7]}}, request.byte2}; // RULE6
            direct_pc   = 1'b1;
         end
         default:          direct_addr = ADDR_RESET; // RULE5
      endcase
   end

   logic needs_mem;
   assign needs_mem = (request.mode == MODE_IDX_IND) || (request.mode == MODE_IND_IDX)
                      || (request.mode == MODE_ABS_IND);

   // ----------------------------------------------------------------
   // Pointer sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state  <= ST_IDLE;
         held   <= '0;
         ptr    <= ADDR_RESET;
         y_snap <= 8'h00;
      end else if (clock_enable) begin
         case (state)
            ST_IDLE: begin
               if (took && needs_mem) begin
                  held   <= request;
                  y_snap <= index_second;
                  state  <= ST_PTR_LO;
                  case (request.mode)
                     MODE_IDX_IND: ptr <= {ZERO_PAGE, zp_add(request.byte2, index_first)}; // RULE7
                     MODE_IND_IDX: ptr <= {ZERO_PAGE, request.byte2}; // RULE9
                     default:      ptr <= {request.byte3, request.byte2}; // RULE10
                  endcase
               end
            end
            ST_PTR_LO: begin
               if (mem_data_valid) begin
                  state <= ST_PTR_HI;
                  if (held.mode == MODE_ABS_IND) ptr <= ptr + ADDR_ONE; // RULE10
                  else ptr <= {ZERO_PAGE, zp_add(ptr[7:0], 8'h01)}; // RULE8
               end
            end
            ST_PTR_HI: begin
               if (mem_data_valid) state <= ST_DONE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Only the pointer low byte goes through the byte store, in entry 0; the high byte comes straight from mem_data.
   logic [7:0] stored_low;

   byte_store #(
      .DEPTH (MEM_DEPTH)
   ) u_store (
      .clock       (clock),
      .rst         (rst),
      .enable      (clock_enable),
      .write_en    (state == ST_PTR_LO && mem_data_valid),
      .write_index ('0),
      .write_data  (mem_data),
      .read_index  ('0),
      .read_data   (stored_low)
   );

   always_ff @(posedge clock or posedge rst) begin
      if (rst) low_byte <= 8'h00;
      else if (clock_enable) low_byte <= stored_low;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic [8:0] low_sum;
   assign low_sum = {1'b0, stored_low} + {1'b0, y_snap};

   // Second pointer fetch address and the finished pointer-mode address.
   logic [15:0] next_fetch;
   logic [15:0] ptr_result;
   assign next_fetch = (held.mode == MODE_ABS_IND) ? ptr + ADDR_ONE
                                                   : {ZERO_PAGE, zp_add(ptr[7:0], 8'h01)}; // RULE8 RULE10
   assign ptr_result = (held.mode == MODE_IND_IDX)
                       ? {mem_data + {7'h00, low_sum[8]}, low_sum[7:0]} // RULE9
                       : {mem_data, stored_low}; // RULE7 RULE10

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         request_ready <= 1'b0;
         mem_req       <= '0;
         result        <= '0;
      end else if (clock_enable) begin
         request_ready <= (state == ST_IDLE) && !(took && needs_mem);
         mem_req.valid <= (state == ST_PTR_LO || state == ST_PTR_HI) && !mem_data_valid
                          || (state == ST_PTR_LO && mem_data_valid);
         mem_req.addr  <= (state == ST_PTR_LO && mem_data_valid) ? next_fetch : ptr; // RULE8
         result.valid  <= 1'b0;
         result.load_pc <= 1'b0;
         if (state == ST_IDLE && took && !needs_mem) begin
            result.valid   <= request.mode != MODE_IMPLIED; // RULE5
            result.load_pc <= direct_pc;
            result.addr    <= direct_addr;
         end else if (state == ST_PTR_HI && mem_data_valid) begin
            result.valid <= 1'b1;
            result.addr  <= ptr_result; // RULE7 RULE9
            result.load_pc <= held.mode == MODE_ABS_IND; // RULE10
         end
      end
   end

   // Only the lowest BUS_WIDTH lines leave the device.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         external_address_lines <= '0;
      end else if (clock_enable) begin
         if (state == ST_PTR_LO && mem_data_valid)
            external_address_lines <= next_fetch[BUS_WIDTH-1:0]; // RULE11 RULE12
         else if (state == ST_PTR_HI && mem_data_valid)
            external_address_lines <= ptr_result[BUS_WIDTH-1:0]; // RULE11 RULE12
         else if (state == ST_IDLE && took && needs_mem)
            external_address_lines <= (request.mode == MODE_IDX_IND)
               ? BUS_WIDTH'({ZERO_PAGE, zp_add(request.byte2, index_first)})
               : (request.mode == MODE_IND_IDX) ? BUS_WIDTH'({ZERO_PAGE, request.byte2})
               : BUS_WIDTH'({request.byte3, request.byte2}); // RULE11 RULE12
         else if (state == ST_IDLE && took)
            external_address_lines <= direct_addr[BUS_WIDTH-1:0]; // RULE11 RULE12
      end
   end

endmodule : effective_address_generator

// *** verification/effective_address_generator_props.sv ***
// Checker for the effective address generator.
`timescale 1ns/1ns
module effective_address_generator_props
   import eag_pkg::*;
#(parameter int unsigned BUS_WIDTH = BUS_W_FULL) (
   // Design ports
   input wire logic                 clock,
   input wire logic                 rst,
   input wire logic                 clock_enable,
   input wire logic [7:0]           index_first,
   input wire logic [7:0]           index_second,
   input wire logic                 request_valid,
   input wire request_s             request,
   input wire logic                 request_ready,
   input wire mem_req_s             mem_req,
   input wire logic                 mem_data_valid,
   input wire logic [7:0]           mem_data,
   input wire result_s              result,
   input wire logic [BUS_WIDTH-1:0] external_address_lines
);
   logic [3:0]  tm;
   logic [7:0]  b2, ix;
   logic [15:0] ra, ba;
   logic        rv;
   assign tm = clock_enable && request_valid && request_ready ? request.mode : 4'hF;
   assign b2 = request.byte2;
   assign ix = request.use_second ? index_second : index_first;
   assign ba = {request.byte3, b2};
   assign ra = result.addr;
   assign rv = result.valid;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_abs; tm == MODE_ABSOLUTE |=> rv && ra == $past(ba); endproperty
   a_abs: assert property (p_abs) else $error("absolute address wrong");
   property p_zp; tm == MODE_ZERO_PAGE |=> rv && ra == {8'h00, $past(b2)}; endproperty
   a_zp: assert property (p_zp) else $error("zero page address wrong");
   property p_zpx; tm == MODE_ZP_INDEXED |=> rv && ra == {8'h00, $past(8'(b2 + ix))}; endproperty
   a_zpx: assert property (p_zpx) else $error("indexed zero page address wrong");
   property p_absx; tm == MODE_ABS_INDEXED |=> rv && ra == $past(ba + 16'(ix)); endproperty
   a_absx: assert property (p_absx) else $error("indexed absolute address wrong");
   property p_impl; tm == MODE_IMPLIED |=> !rv && !mem_req.valid; endproperty
   a_impl: assert property (p_impl) else $error("implied mode produced an address");
   property p_rel; tm == MODE_RELATIVE |=> rv && ra == $past(request.next_pc + 16'(signed'(b2))); endproperty
   a_rel: assert property (p_rel) else $error("branch target wrong");
   property p_ptr; tm == MODE_IDX_IND |-> ##2 mem_req.valid
      && mem_req.addr == {8'h00, $past(8'(b2 + index_first), 2)};
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer fetch address wrong");
   property p_ext; rv |-> (external_address_lines == ra[BUS_WIDTH-1:0])
      or (##1 external_address_lines == $past(ra[BUS_WIDTH-1:0])); endproperty
   a_ext: assert property (p_ext) else $error("address lines wrong");
   c_pc: cover property (rv && result.load_pc);
   c_iy: cover property (tm == MODE_IND_IDX);
   c_wrap: cover property (tm == MODE_ZP_INDEXED && 8'(b2 + ix) < b2);
endmodule : effective_address_generator_props
bind effective_address_generator effective_address_generator_props #(.BUS_WIDTH(BUS_WIDTH)) u_props (
   .clock(clock), .rst(rst), .clock_enable(clock_enable), .index_first(index_first),
   .index_second(index_second), .request_valid(request_valid), .request(request),
   .request_ready(request_ready), .mem_req(mem_req), .mem_data_valid(mem_data_valid),
   .mem_data(mem_data), .result(result), .external_address_lines(external_address_lines));

// *** verification/eag_memory_model.sv ***
// Memory model answering pointer reads with a byte derived from the address.
`timescale 1ns/1ns
module eag_memory_model
   import eag_pkg::*;
(
   // Clock, reset and answer delay
   input wire logic       clock,
   input wire logic       rst,
   input wire logic [1:0] latency,
   // Pointer read port
   input wire mem_req_s   mem_req,
   output logic           mem_data_valid,
   output logic [7:0]     mem_data
);
   logic [1:0] count;
   logic       gap;
   // The data line flips every cycle outside an answer, so a late sample shows.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mem_data_valid <= 1'b0;
         mem_data <= 8'h00;
         count <= 2'd0;
         gap <= 1'b0;
      end else begin
         mem_data_valid <= 1'b0;
         mem_data <= ~mem_data;
         gap <= 1'b0;
         if (mem_req.valid && !gap) begin
            count <= count + 2'd1;
            if (count == latency) begin
               mem_data_valid <= 1'b1;
               mem_data <= mem_req.addr[7:0] ^ mem_req.addr[15:8] ^ 8'h5A;
               count <= 2'd0;
               gap <= 1'b1;
            end
         end
      end
   end
endmodule : eag_memory_model

// *** verification/effective_address_generator_bench.sv ***
// Self-checking bench for the effective address generator.
`timescale 1ns/1ns
module effective_address_generator_bench
   import eag_pkg::*;
;
   logic                clock, rst, clock_enable, request_valid, request_ready, mem_data_valid;
   logic [7:0]          index_first, index_second, mem_data;
   logic [1:0]          latency;
   logic [BUS_W_8K-1:0] external_address_lines;
   logic [BUS_W_4K-1:0] lines_4k;
   request_s            request;
   mem_req_s            mem_req;
   result_s             result;
   result_s             exp_q[$];
   int                  n_mismatch, num_checks;
   effective_address_generator #(.BUS_WIDTH(BUS_W_8K)) u_effective_address_generator (
      .clock(clock), .rst(rst), .clock_enable(clock_enable), .index_first(index_first),
      .index_second(index_second), .request_valid(request_valid), .request(request),
      .request_ready(request_ready), .mem_req(mem_req), .mem_data_valid(mem_data_valid),
      .mem_data(mem_data), .result(result), .external_address_lines(external_address_lines));
   effective_address_generator #(.BUS_WIDTH(BUS_W_4K)) u_effective_address_generator_4k (
      .clock(clock), .rst(rst), .clock_enable(clock_enable), .index_first(index_first),
      .index_second(index_second), .request_valid(request_valid), .request(request),
      .request_ready(), .mem_req(), .mem_data_valid(mem_data_valid),
      .mem_data(mem_data), .result(), .external_address_lines(lines_4k));
   eag_memory_model u_eag_memory_model (.clock(clock), .rst(rst), .latency(latency),
      .mem_req(mem_req), .mem_data_valid(mem_data_valid), .mem_data(mem_data));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   function automatic logic [7:0] mem_at(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction : mem_at
   task automatic compare_result(input result_s got, input result_s want);
      num_checks++;
      if (got !== want) begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, want);
      end
   endtask : compare_result
   task automatic compare_lines(input logic [15:0] got, input logic [15:0] want);
      num_checks++;
      if (got !== want) begin
         n_mismatch++;
         $display("CHECK FAILED %0t lines got %h want %h", $time, got, want);
      end
   endtask : compare_lines
   always @(posedge clock) begin : watch
      result_s w;
      if (result.valid === 1'b1 && exp_q.size() == 0) compare_result(result, '0);
      else if (result.valid === 1'b1) begin
         w = exp_q.pop_front();
         compare_result(result, w);
         compare_lines(16'(external_address_lines), 16'(w.addr[BUS_W_8K-1:0]));
         compare_lines(16'(lines_4k), 16'(w.addr[BUS_W_4K-1:0]));
      end
   end
   task automatic send(input mode_e m, input logic [7:0] b2, b3, i1, i2, input logic [15:0] pc);
      logic [7:0]  p;
      logic [8:0]  s;
      logic [15:0] a;
      logic        u;
      u = (m == MODE_IND_IDX) || (m != MODE_IDX_IND && b3[0]);
      p = b2 + i1;
      s = mem_at({8'h00, b2}) + i2;
      case (m)
         MODE_ABSOLUTE: a = {b3, b2};
         MODE_ZERO_PAGE: a = {8'h00, b2};
         MODE_ZP_INDEXED: a = {8'h00, 8'(b2 + (u ? i2 : i1))};
         MODE_ABS_INDEXED: a = {b3, b2} + (u ? i2 : i1);
         MODE_RELATIVE: a = pc + 16'(signed'(b2));
         MODE_IDX_IND: a = {mem_at({8'h00, 8'(p + 1)}), mem_at({8'h00, p})};
         MODE_IND_IDX: a = {8'(mem_at({8'h00, 8'(b2 + 1)}) + s[8]), s[7:0]};
         default: a = {mem_at({b3, b2} + 16'd1), mem_at({b3, b2})};
      endcase
      index_first <= i1;
      index_second <= i2;
      request <= '{m, u, b2, b3, pc};
      request_valid <= 1'b1;
      do @(posedge clock); while (request_ready !== 1'b1 || clock_enable !== 1'b1);
      if (m != MODE_IMPLIED) exp_q.push_back('{1'b1, m == MODE_ABS_IND || m == MODE_RELATIVE, a});
      // The next request is held off until a pointer sequence has finished and its result has been checked.
      if (m >= MODE_IDX_IND) begin
         request_valid <= 1'b0;
         wait (exp_q.size() == 0);
         @(posedge clock);
      end
   endtask : send
   task automatic conclude();
      n_mismatch += exp_q.size();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   initial begin
      void'($urandom(32'h4EA51225));
      rst = 1'b1;
      clock_enable = 1'b1;
      request_valid = 1'b0;
      request = '0;
      latency = 2'd0;
      index_first = 8'h00;
      index_second = 8'h00;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      send(MODE_ZP_INDEXED, 8'hFF, 8'h01, 8'h00, 8'h01, 16'h0000);
      send(MODE_IDX_IND, 8'hFE, 8'h00, 8'h01, 8'h00, 16'h0000);
      send(MODE_IND_IDX, 8'h10, 8'h00, 8'h00, 8'hFF, 16'h0000);
      send(MODE_RELATIVE, 8'h80, 8'h00, 8'h00, 8'h00, 16'h0100);
      send(MODE_RELATIVE, 8'h7F, 8'h00, 8'h00, 8'h00, 16'hFFF0);
      send(MODE_ABS_IND, 8'hFF, 8'h12, 8'h00, 8'h00, 16'h0000);
      send(MODE_IMPLIED, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000);
      request_valid <= 1'b0;
      clock_enable <= 1'b0;
      repeat (3) @(posedge clock);
      clock_enable <= 1'b1;
      for (int i = 0; i < 180; i++) begin
         latency <= 2'($urandom);
         send(mode_e'(i % 9), 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 16'($urandom));
      end
      request_valid <= 1'b0;
      repeat (8) @(posedge clock);
      conclude();
   end
   initial begin
      repeat (10000) @(posedge clock);
      n_mismatch++;
      conclude();
   end
endmodule : effective_address_generator_bench
